/* File: inc/hpg_map.vh */
// register indices, field positions and reset values of the port pin block
`ifndef HPG_MAP_VH
`define HPG_MAP_VH

// register indices; byte address is four times the index
`define HPG_IDX_PORT_PD 14'h082d
`define HPG_IDX_IND_PD 14'h082f
`define HPG_IDX_PORT_DIR 14'h0831
`define HPG_IDX_IND_DIR 14'h0833
`define HPG_IDX_PORT_OUT 14'h0835
`define HPG_IDX_IND_OUT 14'h0837
`define HPG_IDX_PORT_IN 14'h0839
`define HPG_IDX_IND_IN 14'h083b
`define HPG_IDX_PORT_PU 14'h083d
`define HPG_IDX_FUNC_SEL 14'h0840

// field layout shared by all port pin registers
`define HPG_PORT_MSB 4
`define HPG_PORT_PINS 5
`define HPG_REG_W 8
`define HPG_IND_BIT 0

// reset values
`define HPG_RST_BYTE 8'h00
`define HPG_RST_FUNC 8'h00

// axi response codes
`define HPG_RESP_OKAY 2'b00
`define HPG_RESP_SLVERR 2'b10

`endif

/* File: rtl/hpg_pin_cell.v */
// one pin cell: output enable, output value and input capture
`timescale 1ns/1ps
`default_nettype none
module hpg_pin_cell (
    input wire core_clk,
    input wire reset_n,
    input wire dir_out,
    input wire out_val,
    input wire pin_in,
    output wire pin_out,
    output wire pin_oe,
    output reg in_reg
);
    // drive only while direction selects output
    assign pin_oe = dir_out;
    assign pin_out = out_val;

    // sample the pin level every cycle
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            in_reg <= 1'b0;
        end else begin
            in_reg <= pin_in;
        end
    end
endmodule
`default_nettype wire

/* File: rtl/hpg_port_pin_gpio_regs.v */
// port pin gpio register block with an axi4-lite slave
// Function
// R01: port pin direction bit zero makes input, one drives output
// R02: indicator direction bit 0 selects input or output, upper bits reserved
// R03: port output register value drives each pin set to output
// R04: indicator output bit drives pin only in general-purpose mode
// R05: read-only port input register returns sampled levels in bits 4 to 0
// R06: indicator input bit 0 returns pin level, invalid in indicator mode
// R07: port pull-down bit one enables, zero disables pull-down
// R08: indicator pull-down bit 0 enables its pull-down, upper bits reserved
// R09: port pull-up bit one enables, zero disables pull-up
// R10: bit 0 is vbus, bits 1 to 4 sense pins, 7 to 5 reserved
// R11: function-select bit picks indicator or general-purpose mode
// R12: reserved bits of writable registers store, input reserved bits read zero
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "hpg_map.vh"
module hpg_port_pin_gpio_regs (
    input wire core_clk,
    input wire reset_n,
    // axi4-lite write address
    input wire [15:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    // axi4-lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    // axi4-lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // axi4-lite read address
    input wire [15:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    // axi4-lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // vbus pin and four sense pins
    input wire [4:0] port_pin_in,
    output wire [4:0] port_pin_out,
    output wire [4:0] port_pin_oe,
    output wire [4:0] port_pin_pd_en,
    output wire [4:0] port_pin_pu_en,
    // indicator pin, shared with general_purpose_pin_zero
    input wire indicator_pin_in,
    output wire indicator_pin_out,
    output wire indicator_pin_oe,
    output wire indicator_pin_pd_en,
    input wire indicator_drive,
    output wire indicator_mode
);
    ////////////////////////////////////////////////////////////////////////
    // register storage
    reg [7:0] port_pd_reg;
    reg [7:0] ind_pd_reg;
    reg [7:0] port_dir_reg;
    reg [7:0] ind_dir_reg;
    reg [7:0] port_out_reg;
    reg [7:0] ind_out_reg;
    reg [7:0] port_pu_reg;
    reg [7:0] func_sel_reg;
    wire [4:0] port_in_sync;
    reg ind_in_reg;

    // write channel holding registers
    reg aw_held_reg;
    reg [13:0] aw_idx_reg;
    reg w_held_reg;
    reg [31:0] w_data_reg;
    reg [3:0] w_strb_reg;

    wire wr_fire;
    wire rd_fire;
    wire [13:0] ar_idx;

    // one write strobe per writable register
    reg [7:0] wr_sel;
    // read mux result, taken into rdata on the read edge
    reg [7:0] rd_byte_next;
    reg rd_err_next;

    // bit of wr_sel that strobes each writable register
    localparam SEL_PORT_PD = 0;
    localparam SEL_IND_PD = 1;
    localparam SEL_PORT_DIR = 2;
    localparam SEL_IND_DIR = 3;
    localparam SEL_PORT_OUT = 4;
    localparam SEL_IND_OUT = 5;
    localparam SEL_PORT_PU = 6;
    localparam SEL_FUNC_SEL = 7;

    ////////////////////////////////////////////////////////////////////////
    // axi write path: address and data taken in either order
    assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
    assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
    assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;

    // write address: held until both halves are in
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            aw_held_reg <= 1'b0;
            aw_idx_reg <= 14'h0000;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            aw_idx_reg <= s_axi_awaddr[15:2];
        end else if (wr_fire) begin
            aw_held_reg <= 1'b0;
        end
    end

    // write data: held until both halves are in
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            w_held_reg <= 1'b0;
            w_data_reg <= 32'h00000000;
            w_strb_reg <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_held_reg <= 1'b0;
        end
    end

    // write response: raised as the write completes, dropped on bready
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `HPG_RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_known(aw_idx_reg) ? `HPG_RESP_OKAY :
                `HPG_RESP_SLVERR;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // writable index check; input registers reject writes
    function wr_known;
        input [13:0] idx;
        begin
            case (idx)
                `HPG_IDX_PORT_PD, `HPG_IDX_IND_PD, `HPG_IDX_PORT_DIR,
                `HPG_IDX_IND_DIR, `HPG_IDX_PORT_OUT, `HPG_IDX_IND_OUT,
                `HPG_IDX_PORT_PU, `HPG_IDX_FUNC_SEL: wr_known = 1'b1;
                default: wr_known = 1'b0;
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // write decode: strobe the addressed register as the write completes
    always @* begin
        wr_sel = 8'h00;
        if (wr_fire && w_strb_reg[0]) begin
            case (aw_idx_reg)
                `HPG_IDX_PORT_PD: wr_sel[SEL_PORT_PD] = 1'b1;
                `HPG_IDX_IND_PD: wr_sel[SEL_IND_PD] = 1'b1;
                `HPG_IDX_PORT_DIR: wr_sel[SEL_PORT_DIR] = 1'b1;
                `HPG_IDX_IND_DIR: wr_sel[SEL_IND_DIR] = 1'b1;
                `HPG_IDX_PORT_OUT: wr_sel[SEL_PORT_OUT] = 1'b1;
                `HPG_IDX_IND_OUT: wr_sel[SEL_IND_OUT] = 1'b1;
                `HPG_IDX_PORT_PU: wr_sel[SEL_PORT_PU] = 1'b1;
                `HPG_IDX_FUNC_SEL: wr_sel[SEL_FUNC_SEL] = 1'b1;
                default: wr_sel = 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register writes; byte lane 0 carries the 8-bit value
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            port_pd_reg <= `HPG_RST_BYTE;
            ind_pd_reg <= `HPG_RST_BYTE;
            port_dir_reg <= `HPG_RST_BYTE;
            ind_dir_reg <= `HPG_RST_BYTE;
            port_out_reg <= `HPG_RST_BYTE;
            ind_out_reg <= `HPG_RST_BYTE;
            port_pu_reg <= `HPG_RST_BYTE;
            func_sel_reg <= `HPG_RST_FUNC;
        end else begin
            // full byte stored, reserved bits included  R12
            if (wr_sel[SEL_PORT_PD]) begin
                port_pd_reg <= w_data_reg[7:0]; // R07
            end
            if (wr_sel[SEL_IND_PD]) begin
                ind_pd_reg <= w_data_reg[7:0]; // R08
            end
            if (wr_sel[SEL_PORT_DIR]) begin
                port_dir_reg <= w_data_reg[7:0]; // R01
            end
            if (wr_sel[SEL_IND_DIR]) begin
                ind_dir_reg <= w_data_reg[7:0]; // R02
            end
            if (wr_sel[SEL_PORT_OUT]) begin
                port_out_reg <= w_data_reg[7:0]; // R03
            end
            if (wr_sel[SEL_IND_OUT]) begin
                ind_out_reg <= w_data_reg[7:0]; // R04
            end
            if (wr_sel[SEL_PORT_PU]) begin
                port_pu_reg <= w_data_reg[7:0]; // R09
            end
            if (wr_sel[SEL_FUNC_SEL]) begin
                func_sel_reg <= w_data_reg[7:0]; // R11
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // axi read path: one read at a time, data registered
    assign s_axi_arready = !s_axi_rvalid;
    assign rd_fire = s_axi_arvalid && s_axi_arready;
    assign ar_idx = s_axi_araddr[15:2];

    // read mux: addressed byte, or an error for a hole in the map
    always @* begin
        rd_byte_next = `HPG_RST_BYTE;
        rd_err_next = 1'b0;
        case (ar_idx)
            `HPG_IDX_PORT_PD: rd_byte_next = port_pd_reg;
            `HPG_IDX_IND_PD: rd_byte_next = ind_pd_reg;
            `HPG_IDX_PORT_DIR: rd_byte_next = port_dir_reg;
            `HPG_IDX_IND_DIR: rd_byte_next = ind_dir_reg;
            `HPG_IDX_PORT_OUT: rd_byte_next = port_out_reg;
            `HPG_IDX_IND_OUT: rd_byte_next = ind_out_reg;
            `HPG_IDX_PORT_PU: rd_byte_next = port_pu_reg;
            `HPG_IDX_FUNC_SEL: rd_byte_next = func_sel_reg;
            // sampled levels, reserved bits zero
            `HPG_IDX_PORT_IN: rd_byte_next = {3'h0, port_in_sync}; // R05 R12
            // level meaningless in indicator mode
            `HPG_IDX_IND_IN: rd_byte_next = {7'h0, ind_in_reg}; // R06 R12
            default: rd_err_next = 1'b1;
        endcase
    end

    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `HPG_RESP_OKAY;
        end else if (rd_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, rd_byte_next};
            s_axi_rresp <= rd_err_next ? `HPG_RESP_SLVERR : `HPG_RESP_OKAY;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // port pins: one cell per bit of the shared map
    genvar gi;
    generate
        for (gi = 0; gi < `HPG_PORT_PINS; gi = gi + 1) begin : g_pin
            hpg_pin_cell u_cell (
                .core_clk(core_clk),
                .reset_n(reset_n),
                .dir_out(port_dir_reg[gi]), // R01 R10
                .out_val(port_out_reg[gi]), // R03
                .pin_in(port_pin_in[gi]),
                .pin_out(port_pin_out[gi]),
                .pin_oe(port_pin_oe[gi]),
                .in_reg(port_in_sync[gi]) // R05
            );
        end
    endgenerate

    // pull controls follow register bits 4 to 0
    assign port_pin_pd_en = port_pd_reg[`HPG_PORT_MSB:0]; // R07 R10
    assign port_pin_pu_en = port_pu_reg[`HPG_PORT_MSB:0]; // R09 R10

    ////////////////////////////////////////////////////////////////////////
    // indicator pin: mode bit picks indicator engine or gpio
    assign indicator_mode = func_sel_reg[`HPG_IND_BIT]; // R11
    assign indicator_pin_oe = indicator_mode ? 1'b1 :
        ind_dir_reg[`HPG_IND_BIT]; // R02
    assign indicator_pin_out = indicator_mode ? indicator_drive :
        ind_out_reg[`HPG_IND_BIT]; // R04
    assign indicator_pin_pd_en = ind_pd_reg[`HPG_IND_BIT]; // R08

    // indicator input sample
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            ind_in_reg <= 1'b0;
        end else begin
            ind_in_reg <= indicator_pin_in; // R06
        end
    end
endmodule
`default_nettype wire

/* File: sim/hpg_gpio_props.sv */
// assertions on the ports of the port pin register block
`timescale 1ns/1ps
`default_nettype none
module hpg_gpio_props (
    input wire core_clk,
    input wire reset_n,
    input wire s_axi_arready,
    input wire s_axi_arvalid,
    input wire s_axi_bvalid,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_rvalid,
    input wire [31:0] s_axi_rdata,
    input wire [4:0] port_pin_oe,
    input wire [4:0] port_pin_out,
    input wire [4:0] port_pin_pd_en,
    input wire [4:0] port_pin_pu_en,
    input wire indicator_pin_oe,
    input wire indicator_pin_out,
    input wire indicator_drive,
    input wire indicator_mode
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    // pin controls move only as a write completes
    a_oe_on_write: assert property ($changed(port_pin_oe) |->
        $rose(s_axi_bvalid)) else $error("pin enables moved without write");
    a_out_on_write: assert property ($changed(port_pin_out) |->
        $rose(s_axi_bvalid)) else $error("pin data moved without write");
    a_pd_on_write: assert property ($changed(port_pin_pd_en) |->
        $rose(s_axi_bvalid)) else $error("pull-downs moved without write");
    a_pu_on_write: assert property ($changed(port_pin_pu_en) |->
        $rose(s_axi_bvalid)) else $error("pull-ups moved without write");
    // indicator mode hands the pin to the indicator engine
    a_mode_drives: assert property (indicator_mode |->
        indicator_pin_oe && indicator_pin_out == indicator_drive)
        else $error("indicator mode does not drive pin");
    a_gp_dir_hold: assert property (!indicator_mode &&
        $changed(indicator_pin_oe) |-> $rose(s_axi_bvalid))
        else $error("indicator enable moved without write");
    // read channel handshake and width
    a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address accepted while data pending");
    a_read_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("upper read data not zero");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid) else $error("read data not one cycle after address");
    cover property ($rose(indicator_mode));
    cover property ($rose(s_axi_bvalid) && s_axi_bresp == 2'b10);
    cover property ($changed(port_pin_oe));
endmodule
bind hpg_port_pin_gpio_regs hpg_gpio_props u_props (.*);
`default_nettype wire

/* File: sim/hpg_board_model.sv */
// board model of the vbus, sense and indicator pins
`timescale 1ns/1ps
`default_nettype none
module hpg_board_model (
    input wire logic [4:0] port_pin_oe,
    input wire logic [4:0] port_pin_out,
    input wire logic [4:0] port_pin_pd_en,
    input wire logic [4:0] port_pin_pu_en,
    input wire logic [4:0] ext_en,
    input wire logic [4:0] ext_val,
    output logic [4:0] port_pin_in,
    input wire logic indicator_pin_oe,
    input wire logic indicator_pin_out,
    input wire logic indicator_pin_pd_en,
    output logic indicator_pin_in
);
    // port pins: device drive wins, then board drive, then pulls; open lines flip; indicator pull-down overrides ext_val[0]
    assign port_pin_in = (port_pin_oe & port_pin_out)
        | (~port_pin_oe & ext_en & ext_val)
        | (~port_pin_oe & ~ext_en & (port_pin_pu_en
        | (~port_pin_pd_en & ~ext_val)));
    assign indicator_pin_in = indicator_pin_oe ? indicator_pin_out
        : (!indicator_pin_pd_en && ext_val[0]);
endmodule
`default_nettype wire

/* File: sim/tb.sv */
// self-checking bench for the port pin register block
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [15:0] s_axi_awaddr = 16'h0, s_axi_araddr = 16'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_arready, s_axi_bvalid;
    logic s_axi_rvalid, indicator_pin_in, indicator_pin_out;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [4:0] port_pin_in, port_pin_out, port_pin_oe, port_pin_pd_en;
    logic [4:0] port_pin_pu_en, ext_val = 5'h0, ext_en = 5'h1f;
    logic indicator_pin_oe, indicator_pin_pd_en, indicator_mode;
    logic indicator_drive = 1'b0;
    logic [15:0] addrs [8] = '{16'h20b4, 16'h20bc, 16'h20c4, 16'h20cc,
        16'h20d4, 16'h20dc, 16'h20f4, 16'h2100};
    logic [7:0] vals [8] = '{8'he5, 8'h81, 8'hf6, 8'h83, 8'h6a, 8'ha1,
        8'h73, 8'h80};
    wire [19:0] pins = {port_pin_oe, port_pin_out, port_pin_pd_en,
        port_pin_pu_en};
    wire [3:0] ind = {indicator_pin_oe, indicator_pin_out,
        indicator_pin_pd_en, indicator_mode};
    int num_errors = 0;
    int n_tests = 0;
    hpg_port_pin_gpio_regs u_dut (
        .core_clk, .reset_n, .s_axi_awaddr, .s_axi_awprot(3'h0),
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready(1'b1), .s_axi_araddr, .s_axi_arprot(3'h0),
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready(1'b1), .port_pin_in, .port_pin_out,
        .port_pin_oe, .port_pin_pd_en, .port_pin_pu_en, .indicator_pin_in,
        .indicator_pin_out, .indicator_pin_oe, .indicator_pin_pd_en,
        .indicator_drive, .indicator_mode);
    hpg_board_model u_board (.port_pin_oe, .port_pin_out, .port_pin_pd_en,
        .port_pin_pu_en, .ext_en, .ext_val, .port_pin_in, .indicator_pin_oe,
        .indicator_pin_out, .indicator_pin_pd_en, .indicator_pin_in);
    always #5 core_clk = ~core_clk;
    ////////////////////////////////////////////////////////////////////////
    // compare and count
    task automatic chk(input string nm, logic [31:0] ex, logic [31:0] got);
        n_tests++;
        if (got !== ex) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, ex, got);
        end
    endtask
    // axi4-lite write; bready held high throughout
    task automatic wr(input logic [15:0] a, logic [7:0] d, logic [3:0] s,
            logic [1:0] er);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge core_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        chk("bresp", er, s_axi_bresp);
    endtask
    // axi4-lite read; rready held high throughout
    task automatic rd(input logic [15:0] a, logic [7:0] ex, logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge core_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        chk("rdata", {24'h0, ex}, s_axi_rdata);
        chk("rresp", er, s_axi_rresp);
    endtask
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // watchdog: tests take about a hundred cycles, limit is 5000
    initial begin
        #50000;
        num_errors++;
        print_verdict();
    end
    // test sequence
    initial begin
        repeat (8) @(posedge core_clk);
        reset_n <= 1'b1;
        @(posedge core_clk);
        for (int i = 0; i < 8; i++) rd(addrs[i], 8'h00, 2'b00);
        rd(16'h20e4, 8'h00, 2'b00);
        rd(16'h20ec, 8'h00, 2'b00);
        $display("reset values test done");
        ext_en <= 5'h08;
        ext_val <= 5'h08;
        for (int i = 0; i < 8; i++) wr(addrs[i], vals[i], 4'h1, 2'b00);
        for (int i = 0; i < 8; i++) rd(addrs[i], vals[i], 2'b00);
        chk("port pins", 32'hb28b3, pins);
        chk("indicator pins", 32'he, ind);
        rd(16'h20e4, 8'h0b, 2'b00);
        rd(16'h20ec, 8'h01, 2'b00);
        $display("readback and pins test done");
        wr(16'h20e4, 8'hff, 4'h1, 2'b10);
        wr(16'h2104, 8'hff, 4'h1, 2'b10);
        wr(16'h20c4, 8'h00, 4'h0, 2'b00);
        rd(16'h20c4, 8'hf6, 2'b00);
        rd(16'h20e4, 8'h0b, 2'b00);
        rd(16'h2104, 8'h00, 2'b10);
        $display("refusal test done");
        wr(16'h2100, 8'h01, 4'h1, 2'b00);
        wr(16'h20dc, 8'h00, 4'h1, 2'b00);
        indicator_drive <= 1'b1;
        @(posedge core_clk);
        chk("indicator drive high", 32'hf, ind);
        indicator_drive <= 1'b0;
        @(posedge core_clk);
        chk("indicator drive low", 32'hb, ind);
        wr(16'h2100, 8'h00, 4'h1, 2'b00);
        chk("gp output", 32'ha, ind);
        wr(16'h20cc, 8'h00, 4'h1, 2'b00);
        chk("gp input", 32'h2, ind);
        $display("indicator mode test done");
        print_verdict();
    end
endmodule
`default_nettype wire
